// ---- hdl/exchange_op_table_translate_op_xor_exec.v ----
// Execution unit: exchange, table translate, exclusive OR and exceptions
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module exchange_op_table_translate_op_xor_exec (
  input wire REF_CLK,
  input wire RST_N,
  input wire START,
  input wire [7:0] OPCODE,
  input wire [7:0] MODRM,
  input wire HAS_MEM,
  input wire [15:0] OPND_DST,
  input wire [15:0] OPND_SRC,
  input wire [15:0] BX_VALUE,
  input wire [7:0] MEM_RDATA,
  input wire [15:0] INSTR_CS,
  input wire [15:0] INSTR_IP,
  input wire PROT_MODE,
  input wire MEM_WRITABLE,
  input wire EA_ILLEGAL,
  input wire EA_IN_STACK,
  input wire [15:0] EA_OFFSET,
  input wire MSW_EM,
  input wire MSW_TS,
  input wire ERROR_N,
  input wire UNDEF_OP,
  input wire BOUND_OP,
  input wire [15:0] BOUND_VALUE,
  input wire [15:0] BOUND_LOWER,
  input wire [15:0] BOUND_UPPER,
  input wire LOAD_INTERRUPT_TABLE_OP_OP,
  input wire [15:0] LOAD_INTERRUPT_TABLE_OP_LIMIT,
  input wire NPX_XFER,
  input wire [15:0] NPX_OFFSET,
  input wire [15:0] NPX_LEN,
  output reg BUSY,
  output reg DONE,
  output reg LOCK,
  output reg MEM_RD,
  output reg [15:0] TABLE_TRANSLATE_OP_OFFSET,
  output reg [15:0] RESULT_DST,
  output reg [15:0] RESULT_SRC,
  output reg DST_WE,
  output reg SRC_WE,
  output reg FLAGS_WE,
  output reg FLAG_OF,
  output reg FLAG_SF,
  output reg FLAG_ZF,
  output reg FLAG_PF,
  output reg FLAG_CF,
  output reg FAULT,
  output reg [7:0] FAULT_VECTOR,
  output reg FAULT_HAS_CODE,
  output reg [15:0] FAULT_CODE,
  output reg [15:0] SAVED_CS,
  output reg [15:0] SAVED_IP,
  output reg [15:0] IDT_LIMIT,
  output reg [15:0] NPX_PTR_CS,
  output reg [15:0] NPX_PTR_IP
);
  localparam S_IDLE = 1'b0;
  localparam S_RUN = 1'b1;
  localparam [1:0] K_NONE = 2'b00;
  localparam [1:0] K_EXCHANGE_OP = 2'b01;
  localparam [1:0] K_TABLE_TRANSLATE_OP = 2'b10;
  localparam [1:0] K_XOR = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [2:0] ext = MODRM[5:3];
  wire is_exchange_op_rm = (OPCODE == `OPC_EXCHANGE_OP_B) || (OPCODE == `OPC_EXCHANGE_OP_W);
  wire is_exchange_op_acc = (OPCODE[7:3] == `OPC_EXCHANGE_OP_ACC);
  wire is_table_translate_op = (OPCODE == `OPC_TABLE_TRANSLATE_OP);
  wire is_xor_rm = (OPCODE[7:2] == `OPC_XOR_RM);
  wire is_xor_acc = (OPCODE == `OPC_XOR_AL) || (OPCODE == `OPC_XOR_AX);
  wire is_xor_imm = ((OPCODE == `OPC_GRP_B) || (OPCODE == `OPC_GRP_W)) && (ext == `EXT_XOR);
  wire is_xor = is_xor_rm || is_xor_acc || is_xor_imm;
  wire is_esc = (OPCODE[7:3] == `OPC_ESC);
  wire word_op = is_exchange_op_acc ? 1'b1 : (is_table_translate_op ? 1'b0 : OPCODE[0]);
  // Only memory destinations can sit in a read-only segment
  wire mem_dst = is_exchange_op_rm || ((is_xor_rm && !OPCODE[1]) || is_xor_imm);

  reg [1:0] kind;
  reg [3:0] clocks;
  always @*
    begin
    kind = K_NONE;
    clocks = 4'h1;
    if (is_exchange_op_rm) begin
      kind = K_EXCHANGE_OP;
      clocks = HAS_MEM ? `CLK_EXCHANGE_OP_MEM : `CLK_EXCHANGE_OP_REG;
    end else if (is_exchange_op_acc) begin
      kind = K_EXCHANGE_OP;
      clocks = `CLK_EXCHANGE_OP_ACC;
    end else if (is_table_translate_op) begin
      kind = K_TABLE_TRANSLATE_OP;
      clocks = `CLK_TABLE_TRANSLATE_OP;
    end else if (is_xor) begin
      kind = K_XOR;
      if (is_xor_acc)
        clocks = `CLK_XOR_ACC;
      else if (HAS_MEM)
        clocks = `CLK_XOR_MEM;
      else if (is_xor_imm)
        clocks = `CLK_XOR_IMM;
      else
        clocks = `CLK_XOR_REG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception detection
  wire copro_err_n;
  pin_sync #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_err_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(ERROR_N),
    .q(copro_err_n)
  );

  wire bound_out = ($signed(BOUND_VALUE) < $signed(BOUND_LOWER)) ||
                   ($signed(BOUND_VALUE) > $signed(BOUND_UPPER));
  wire [16:0] npx_end = {1'b0, NPX_OFFSET} + {1'b0, NPX_LEN};
  // A transfer may end exactly on the last byte of the segment
  wire npx_over = (NPX_LEN != 16'h0000) && (npx_end > {1'b0, `OFS_MAX} + 17'h00001);
  wire flt;
  wire [7:0] flt_vec;
  wire flt_code;

  fault_select u_fault (
    .opcode(OPCODE),
    .modrm(MODRM),
    .has_mem(HAS_MEM),
    .word_op(word_op),
    .dst_write(mem_dst),
    .prot_mode(PROT_MODE),
    .mem_writable(MEM_WRITABLE),
    .ea_illegal(EA_ILLEGAL),
    .ea_in_stack(EA_IN_STACK),
    .ea_offset(EA_OFFSET),
    .msw_em(MSW_EM),
    .msw_ts(MSW_TS),
    .copro_err(!copro_err_n),
    .undef_op(UNDEF_OP),
    .bound_op(BOUND_OP),
    .bound_out(bound_out),
    .load_interrupt_table_op_op(LOAD_INTERRUPT_TABLE_OP_OP),
    .load_interrupt_table_op_limit(LOAD_INTERRUPT_TABLE_OP_LIMIT),
    .npx_xfer(NPX_XFER),
    .npx_over(npx_over),
    .fault(flt),
    .vector(flt_vec),
    .has_code(flt_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Execution sequencer
  reg state_r;
  reg [3:0] cnt_r;
  reg [1:0] kind_r;
  reg word_r;
  reg [15:0] dst_r;
  reg [15:0] src_r;

  wire accept = START && (state_r == S_IDLE);
  wire finish = (state_r == S_RUN) && (cnt_r == 4'h1);
  wire [15:0] xor_full = dst_r ^ src_r;
  wire [15:0] xor_res = word_r ? xor_full : {8'h00, xor_full[7:0]};
  wire [15:0] dst_trim = word_r ? dst_r : {8'h00, dst_r[7:0]};
  wire [15:0] src_trim = word_r ? src_r : {8'h00, src_r[7:0]};

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      kind_r <= K_NONE;
      word_r <= 1'b0;
      dst_r <= 16'h0000;
      src_r <= 16'h0000;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      LOCK <= 1'b0;
      MEM_RD <= 1'b0;
      TABLE_TRANSLATE_OP_OFFSET <= 16'h0000;
      RESULT_DST <= 16'h0000;
      RESULT_SRC <= 16'h0000;
      DST_WE <= 1'b0;
      SRC_WE <= 1'b0;
      FLAGS_WE <= 1'b0;
      FLAG_OF <= 1'b0;
      FLAG_SF <= 1'b0;
      FLAG_ZF <= 1'b0;
      FLAG_PF <= 1'b0;
      FLAG_CF <= 1'b0;
      FAULT <= 1'b0;
      FAULT_VECTOR <= 8'h00;
      FAULT_HAS_CODE <= 1'b0;
      FAULT_CODE <= `ERR_CODE_ZERO;
      SAVED_CS <= 16'h0000;
      SAVED_IP <= 16'h0000;
      IDT_LIMIT <= `IDT_LIM_RESET;
      NPX_PTR_CS <= 16'h0000;
      NPX_PTR_IP <= 16'h0000;
    end else begin
      DONE <= 1'b0;
      DST_WE <= 1'b0;
      SRC_WE <= 1'b0;
      FLAGS_WE <= 1'b0;
      FAULT <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (accept) begin
            SAVED_CS <= INSTR_CS;
            SAVED_IP <= INSTR_IP;
            // limit is loaded even when it faults
            if (LOAD_INTERRUPT_TABLE_OP_OP)
              IDT_LIMIT <= LOAD_INTERRUPT_TABLE_OP_LIMIT;
            if (flt) begin
              // no writes or flags on a fault
              FAULT <= 1'b1;
              DONE <= 1'b1;
              FAULT_VECTOR <= flt_vec;
              FAULT_HAS_CODE <= flt_code;
              FAULT_CODE <= `ERR_CODE_ZERO;
            end else if (kind == K_NONE) begin
              DONE <= 1'b1;
              if (is_esc) begin
                NPX_PTR_CS <= INSTR_CS;
                NPX_PTR_IP <= INSTR_IP;
              end
            end else begin
              state_r <= S_RUN;
              BUSY <= 1'b1;
              cnt_r <= clocks - 4'h1;
              kind_r <= kind;
              word_r <= word_op;
              dst_r <= OPND_DST;
              src_r <= OPND_SRC;
              LOCK <= (kind == K_EXCHANGE_OP);
              MEM_RD <= (kind == K_TABLE_TRANSLATE_OP);
              // table address from base plus index
              TABLE_TRANSLATE_OP_OFFSET <= BX_VALUE + {8'h00, OPND_DST[7:0]};
            end
          end
        end
        S_RUN: begin
          if (finish) begin
            state_r <= S_IDLE;
            BUSY <= 1'b0;
            DONE <= 1'b1;
            LOCK <= 1'b0;
            MEM_RD <= 1'b0;
            case (kind_r)
              K_EXCHANGE_OP: begin
                RESULT_DST <= src_trim;
                RESULT_SRC <= dst_trim;
                DST_WE <= 1'b1;
                SRC_WE <= 1'b1;
              end
              K_TABLE_TRANSLATE_OP: begin
                // table byte goes to the low byte, the high byte of the result is zero
                RESULT_DST <= {8'h00, MEM_RDATA};
                DST_WE <= 1'b1;
              end
              K_XOR: begin
                RESULT_DST <= xor_res;
                DST_WE <= 1'b1;
                FLAGS_WE <= 1'b1;
                FLAG_OF <= 1'b0;
                FLAG_CF <= 1'b0;
                FLAG_SF <= word_r ? xor_res[15] : xor_res[7];
                FLAG_ZF <= (xor_res == 16'h0000);
                FLAG_PF <= ~^xor_res[7:0];
              end
              default: begin
                RESULT_DST <= RESULT_DST;
              end
            endcase
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
          BUSY <= 1'b0;
          LOCK <= 1'b0;
          MEM_RD <= 1'b0;
        end
      endcase
    end
  end
endmodule // exchange_op_table_translate_op_xor_exec
`default_nettype wire

// ---- hdl/exec_map.vh ----
// Constants for the exchange, translate and exclusive-OR execution unit
// Operation
// - Exchange swaps reg/mem, 3 or 5 clocks
// - 90+reg swaps register with accumulator, 3 clocks
// - Bus lock held through every exchange
// - Exchange into non-writable segment faults GP(0)
// - Illegal address: GP(0), stack segment SS(0)
// - Translate loads low accumulator from table, 5 clocks
// - Exclusive OR result replaces first operand
// - Exclusive OR clears OF, CF; sets SF, ZF, PF
// - Exclusive OR takes 2/7, accumulator and immediate-to-register forms 3
// - Exclusive OR into non-writable destination faults GP(0)
// - Saved pointer marks first prefix byte
// - Range check outside limits raises vector 5
// - Undefined opcode raises vector 6
// - Escape with emulate, wait with switched: 7
// - Table limit 20H-43H raises 8; resets 3FFH
// - Coprocessor transfer past FFFFH raises vector 9
// - Word access at offset FFFFH raises 13
// - Coprocessor op with error pin raises 16
// - Bad push/pop memory encodings raise 13
// - Code segment loads never happen; vector 6
// - Coprocessor pointer marks leading prefixes
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH
`define OPC_EXCHANGE_OP_B 8'h86
`define OPC_EXCHANGE_OP_W 8'h87
`define OPC_EXCHANGE_OP_ACC 5'h12
`define OPC_TABLE_TRANSLATE_OP 8'hD7
`define OPC_XOR_RM 6'h0C
`define OPC_XOR_AL 8'h34
`define OPC_XOR_AX 8'h35
`define OPC_GRP_B 8'h80
`define OPC_GRP_W 8'h81
`define EXT_XOR 3'h6
`define OPC_ESC 5'h1B
`define OPC_WAIT 8'h9B
`define OPC_POP_MEM 8'h8F
`define OPC_GRP_FF 8'hFF
`define OPC_MOV_SREG 8'h8E
`define EXT_POP 3'h0
`define EXT_FF_BAD 3'h7
`define SREG_CS 3'h1
`define CLK_EXCHANGE_OP_REG 4'h3
`define CLK_EXCHANGE_OP_MEM 4'h5
`define CLK_EXCHANGE_OP_ACC 4'h3
`define CLK_TABLE_TRANSLATE_OP 4'h5
`define CLK_XOR_REG 4'h2
`define CLK_XOR_MEM 4'h7
`define CLK_XOR_ACC 4'h3
`define CLK_XOR_IMM 4'h3
`define VEC_BOUND 8'h05
`define VEC_UNDEF 8'h06
`define VEC_NO_COPRO 8'h07
`define VEC_IDT_LIMIT 8'h08
`define VEC_COPRO_SEG 8'h09
`define VEC_STACK 8'h0C
`define VEC_GPROT 8'h0D
`define VEC_COPRO_ERR 8'h10
`define IDT_LIM_RESET 16'h03FF
`define IDT_LIM_LO 16'h0020
`define IDT_LIM_HI 16'h0043
`define OFS_MAX 16'hFFFF
`define ERR_CODE_ZERO 16'h0000
`endif

// ---- hdl/pin_sync.v ----
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ---- hdl/fault_select.v ----
// Prioritised exception detection for one instruction
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module fault_select (
  input wire [7:0] opcode,
  input wire [7:0] modrm,
  input wire has_mem,
  input wire word_op,
  input wire dst_write,
  input wire prot_mode,
  input wire mem_writable,
  input wire ea_illegal,
  input wire ea_in_stack,
  input wire [15:0] ea_offset,
  input wire msw_em,
  input wire msw_ts,
  input wire copro_err,
  input wire undef_op,
  input wire bound_op,
  input wire bound_out,
  input wire load_interrupt_table_op_op,
  input wire [15:0] load_interrupt_table_op_limit,
  input wire npx_xfer,
  input wire npx_over,
  output reg fault,
  output reg [7:0] vector,
  output reg has_code
);
  wire [2:0] ext = modrm[5:3];
  wire is_esc = (opcode[7:3] == `OPC_ESC);
  wire is_wait = (opcode == `OPC_WAIT);

  // Earlier branches win when several causes coincide
  always @* begin
    fault = 1'b1;
    vector = `VEC_UNDEF;
    has_code = 1'b0;
    if (undef_op) begin
      vector = `VEC_UNDEF;
    end else if (opcode == `OPC_MOV_SREG && ext == `SREG_CS) begin
      vector = `VEC_UNDEF;
    end else if ((opcode == `OPC_POP_MEM && ext != `EXT_POP) ||
                 (opcode == `OPC_GRP_FF && ext == `EXT_FF_BAD)) begin
      vector = `VEC_GPROT;
    end else if ((is_esc && msw_em) || (is_wait && msw_ts)) begin
      vector = `VEC_NO_COPRO;
    end else if ((is_esc || is_wait) && copro_err) begin
      vector = `VEC_COPRO_ERR;
    end else if (bound_op && bound_out) begin
      vector = `VEC_BOUND;
    end else if (load_interrupt_table_op_op && load_interrupt_table_op_limit >= `IDT_LIM_LO && load_interrupt_table_op_limit <= `IDT_LIM_HI) begin
      vector = `VEC_IDT_LIMIT;
    end else if (prot_mode && has_mem && ea_illegal) begin
      vector = ea_in_stack ? `VEC_STACK : `VEC_GPROT;
      has_code = 1'b1;
    end else if (prot_mode && has_mem && dst_write && !mem_writable) begin
      vector = `VEC_GPROT;
      has_code = 1'b1;
    end else if (has_mem && word_op && ea_offset == `OFS_MAX) begin
      vector = `VEC_GPROT;
    end else if (npx_xfer && npx_over) begin
      vector = `VEC_COPRO_SEG;
    end else begin
      fault = 1'b0;
    end
  end
endmodule // fault_select
`default_nettype wire

// ---- sim/mem_copro_model.sv ----
// Table memory and coprocessor error pin model facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module mem_copro_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [15:0] offset,
  input wire logic err_req,
  output logic [7:0] rdata,
  output logic error_n
);
  logic [7:0] last_r = 8'h00;
  logic err_r = 1'b1;
  always @(posedge clk) begin
    if (mem_rd) begin
      last_r <= offset[7:0] ^ offset[15:8] ^ 8'hA5;
    end
  end
  // Released bus shows the inverse of the last byte so a stale read is caught
  assign rdata = mem_rd ? (offset[7:0] ^ offset[15:8] ^ 8'hA5) : ~last_r;
  // unmasked error pin
  // Pin is asynchronous, so it moves away from the clock edge
  always @(err_req) err_r <= #7 ~err_req;
  assign error_n = err_r;
endmodule // mem_copro_model
`default_nettype wire

// ---- sim/exec_checker_sva.sv ----
// Port-level assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic HAS_MEM,
  input wire logic PROT_MODE,
  input wire logic UNDEF_OP,
  input wire logic BOUND_OP,
  input wire logic LOAD_INTERRUPT_TABLE_OP_OP,
  input wire logic NPX_XFER,
  input wire logic MSW_EM,
  input wire logic MSW_TS,
  input wire logic [15:0] EA_OFFSET,
  input wire logic [15:0] INSTR_CS,
  input wire logic [15:0] INSTR_IP,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic LOCK,
  input wire logic MEM_RD,
  input wire logic [15:0] RESULT_DST,
  input wire logic DST_WE,
  input wire logic SRC_WE,
  input wire logic FLAGS_WE,
  input wire logic FLAG_OF,
  input wire logic FLAG_ZF,
  input wire logic FLAG_PF,
  input wire logic FLAG_CF,
  input wire logic FAULT,
  input wire logic [7:0] FAULT_VECTOR,
  input wire logic [15:0] FAULT_CODE,
  input wire logic [15:0] SAVED_CS,
  input wire logic [15:0] SAVED_IP,
  input wire logic [15:0] IDT_LIMIT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Accepted request with no fault source present
  wire logic take = START && !BUSY && !PROT_MODE && !UNDEF_OP && !BOUND_OP && !LOAD_INTERRUPT_TABLE_OP_OP && !NPX_XFER
    && !MSW_EM && !MSW_TS && EA_OFFSET != 16'hFFFF;
  AST_LOCK_BUSY: assert property (LOCK |-> BUSY)
    else $error("lock high outside a busy cycle");
  AST_EXCHANGE_OP_ACC: assert property (take && OPCODE[7:3] == 5'h12 |=> LOCK [*2] ##1 (DONE && !LOCK && DST_WE && SRC_WE))
    else $error("accumulator exchange timing or lock wrong");
  AST_EXCHANGE_OP_MEM: assert property (take && OPCODE[7:1] == 7'h43 && HAS_MEM |=> (LOCK && !DONE) [*4] ##1 (DONE && !LOCK && !FLAGS_WE))
    else $error("memory exchange timing or lock wrong");
  AST_XOR_REG: assert property (take && OPCODE[7:2] == 6'h0C && !HAS_MEM |=> !DONE ##1 (DONE && DST_WE && FLAGS_WE))
    else $error("register exclusive OR timing wrong");
  AST_XOR_FLAGS: assert property (FLAGS_WE |-> !FLAG_OF && !FLAG_CF && FLAG_ZF == (RESULT_DST == 16'h0000)
    && FLAG_PF == ~^RESULT_DST[7:0])
    else $error("exclusive OR flags wrong");
  AST_TABLE_TRANSLATE_OP: assert property (take && OPCODE == 8'hD7 |=> MEM_RD [*4] ##1 (DONE && !MEM_RD && DST_WE
    && RESULT_DST[15:8] == 8'h00 && !FLAGS_WE))
    else $error("translate timing or result wrong");
  AST_FAULT_QUIET: assert property (FAULT |-> DONE && !DST_WE && !SRC_WE && !FLAGS_WE && FAULT_CODE == 16'h0000)
    else $error("fault wrote state or gave a nonzero code");
  AST_SAVED_PTR: assert property (START && !BUSY |=> SAVED_CS == $past(INSTR_CS) && SAVED_IP == $past(INSTR_IP))
    else $error("saved pointer does not match the instruction start");
  AST_UNDEF: assert property (START && !BUSY && UNDEF_OP |=> FAULT && FAULT_VECTOR == 8'h06)
    else $error("undefined opcode did not raise vector 6");
  AST_IDT_RESET: assert property (!$past(RST_N) |-> IDT_LIMIT == 16'h03FF)
    else $error("table limit not at its reset value");
endmodule // exec_checker
bind exchange_op_table_translate_op_xor_exec exec_checker exec_checker_inst (.*);
`default_nettype wire

// ---- sim/swap_lookup_exclusive_or_exec_test.sv ----
// Self-checking bench for the exchange, translate and exclusive-OR unit
`timescale 1ns/1ps
`default_nettype none
module swap_lookup_exclusive_or_exec_test;
  logic REF_CLK = 1'b0, RST_N = 1'b0, START = 1'b0, HAS_MEM = 1'b0, PROT_MODE = 1'b0, MEM_WRITABLE = 1'b1;
  logic EA_ILLEGAL = 1'b0, EA_IN_STACK = 1'b0, MSW_EM = 1'b0, MSW_TS = 1'b0, UNDEF_OP = 1'b0, BOUND_OP = 1'b0;
  logic LOAD_INTERRUPT_TABLE_OP_OP = 1'b0, NPX_XFER = 1'b0, err_req = 1'b0;
  logic [7:0] OPCODE = 8'h00, MODRM = 8'h00;
  logic [15:0] OPND_DST = 16'h0, OPND_SRC = 16'h0, BX_VALUE = 16'h0, INSTR_CS = 16'h0, INSTR_IP = 16'h0;
  logic [15:0] EA_OFFSET = 16'h0, BOUND_VALUE = 16'h0, LOAD_INTERRUPT_TABLE_OP_LIMIT = 16'h0, NPX_LEN = 16'h0;
  logic [15:0] BOUND_LOWER = 16'h0040, BOUND_UPPER = 16'h0060, NPX_OFFSET = 16'hFFF8;
  wire logic ERROR_N;
  wire logic [7:0] MEM_RDATA;
  logic BUSY, DONE, LOCK, MEM_RD, DST_WE, SRC_WE, FLAGS_WE, FLAG_OF, FLAG_SF, FLAG_ZF, FLAG_PF, FLAG_CF;
  logic FAULT, FAULT_HAS_CODE;
  logic [7:0] FAULT_VECTOR;
  logic [15:0] TABLE_TRANSLATE_OP_OFFSET, RESULT_DST, RESULT_SRC, FAULT_CODE, SAVED_CS, SAVED_IP, IDT_LIMIT, NPX_PTR_CS, NPX_PTR_IP;
  typedef struct {logic [3:0] ev; logic [7:0] vec; logic [15:0] rd, rs; logic [4:0] fl; int c, t; logic [15:0] cs, ip;} exp_t;
  exp_t q[$];
  exp_t m, nil;
  int error_cnt = 0, n_tests = 0, cyc = 0, j, c;
  logic [7:0] op;
  logic [15:0] a, b, r, o;
  // Fault table: opcode, second byte, condition bits, vector
  logic [39:0] ft [14] = '{
    40'h30_F0_0040_06, // undefined
    40'h8E_C8_0000_06, // code load
    40'h8F_18_0800_0D, // pop encoding
    40'hFF_38_0800_0D, // push encoding
    40'hD8_C0_0010_07, // emulate set
    40'h9B_00_0020_07, // switched wait
    40'h62_00_0080_05, // out of range
    40'h0F_18_0100_08, // small limit
    40'h31_00_0805_0D, // illegal address
    40'h31_00_080D_0C, // stack address
    40'h87_00_0803_0D, // exchange readonly
    40'h30_00_0803_0D, // xor readonly
    40'h31_00_0C00_0D, // word wrap
    40'hDD_00_0200_09}; // transfer overrun
  logic [7:0] xo [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h80, 8'h81};
  exchange_op_table_translate_op_xor_exec exchange_op_table_translate_op_xor_exec_inst (.*);
  mem_copro_model mem_copro_model_inst (.clk(REF_CLK), .mem_rd(MEM_RD), .offset(TABLE_TRANSLATE_OP_OFFSET), .err_req(err_req),
    .rdata(MEM_RDATA), .error_n(ERROR_N));
  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic exp_t mk(input logic [3:0] ev, input logic [7:0] vec, input logic [15:0] rd, rs,
    input logic [4:0] fl, input int cl);
    mk = '{ev, vec, rd, rs, fl, cl, 0, 16'h0, 16'h0};
  endfunction
  // Called at a rising edge; returns at the edge where completion is seen
  task go(input logic [7:0] opc, md, input logic [15:0] d, s, input logic [11:0] cf, input exp_t e);
    int i;
    e.cs = 16'($urandom);
    e.ip = 16'($urandom);
    e.t = cyc;
    q.push_back(e);
    START <= 1'b1;
    OPCODE <= opc;
    MODRM <= md;
    OPND_DST <= d;
    OPND_SRC <= s;
    BX_VALUE <= s;
    BOUND_VALUE <= d;
    LOAD_INTERRUPT_TABLE_OP_LIMIT <= d;
    NPX_LEN <= s;
    PROT_MODE <= cf[0];
    MEM_WRITABLE <= ~cf[1];
    EA_ILLEGAL <= cf[2];
    EA_IN_STACK <= cf[3];
    MSW_EM <= cf[4];
    MSW_TS <= cf[5];
    UNDEF_OP <= cf[6];
    BOUND_OP <= cf[7];
    LOAD_INTERRUPT_TABLE_OP_OP <= cf[8];
    NPX_XFER <= cf[9];
    EA_OFFSET <= cf[10] ? 16'hFFFF : 16'h0100;
    HAS_MEM <= cf[11];
    INSTR_CS <= e.cs;
    INSTR_IP <= e.ip;
    @(posedge REF_CLK);
    START <= 1'b0;
    for (i = 0; i < 12 && DONE !== 1'b1; i++) @(posedge REF_CLK);
    if (i == 12) begin
      error_cnt++;
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge REF_CLK) begin
    if (DONE === 1'b1) begin
      if (q.size() == 0) chk(32'h0, 32'h1);
      else begin
        m = q.pop_front();
        chk({FAULT, DST_WE, SRC_WE, FLAGS_WE}, m.ev); // write strobes
        chk(cyc - m.t - 1, m.c); // clocks
        if (m.ev[3]) chk(FAULT_VECTOR, m.vec); // vector number
        if (m.ev[3]) chk(FAULT_HAS_CODE, m.rs[0]); // error code present
        if (m.ev[2]) chk(RESULT_DST, m.rd); // first operand
        if (m.ev[1]) chk(RESULT_SRC, m.rs); // second operand
        if (m.ev[0]) chk({FLAG_OF, FLAG_SF, FLAG_ZF, FLAG_PF, FLAG_CF}, m.fl); // flag values
        chk({SAVED_CS, SAVED_IP}, {m.cs, m.ip}); // saved pointer
      end
    end
  end
  initial begin
    void'($urandom(32'h2369a549));
    nil = mk(4'h0, 8'h00, 16'h0, 16'h0, 5'h0, 1);
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    chk(IDT_LIMIT, 16'h03FF); // reset limit
    for (j = 0; j < 16; j++) begin
      op = xo[j[3:1]];
      if (op[7:1] == 7'h1A && j[0]) continue;
      a = 16'($urandom);
      b = (j == 2) ? a : 16'($urandom);
      r = (a ^ b) & (op[0] ? 16'hFFFF : 16'h00FF);
      c = op[7] ? (j[0] ? 7 : 3) : (op[2] ? 3 : (j[0] ? 7 : 2));
      go(op, j[0] ? 8'h30 : 8'hF0, a, b, {j[0], 11'h0},
        mk(4'h5, 8'h00, r, 16'h0, {1'b0, op[0] ? r[15] : r[7], r == 16'h0, ~^r[7:0], 1'b0}, c));
    end
    for (j = 0; j < 4; j++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      r = j[0] ? 16'hFFFF : 16'h00FF;
      go({7'h43, j[0]}, 8'h00, a, b, {j[1], 11'h0}, mk(4'h6, 8'h00, b & r, a & r, 5'h0, j[1] ? 5 : 3));
    end
    go({5'h12, 3'($urandom)}, 8'h00, a, b, 12'h0, mk(4'h6, 8'h00, b, a, 5'h0, 3)); // accumulator swap
    o = b + {8'h00, a[7:0]};
    go(8'hD7, 8'h00, a, b, 12'h800, mk(4'h4, 8'h00, {8'h00, o[7:0] ^ o[15:8] ^ 8'hA5}, 16'h0, 5'h0, 5));
    chk(TABLE_TRANSLATE_OP_OFFSET, o); // table address
    for (j = 0; j < 14; j++) begin
      // Only the address and writability faults push an error code
      go(ft[j][39:32], ft[j][31:24], 16'h0030, 16'h0010, ft[j][19:8],
        mk(4'h8, ft[j][7:0], 16'h0, {15'h0, j >= 8 && j <= 11}, 5'h0, 1));
    end
    chk(IDT_LIMIT, 16'h0030); // limit still loaded
    err_req <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    go(8'hD9, 8'hC0, 16'h0, 16'h0, 12'h0, mk(4'h8, 8'h10, 16'h0, 16'h0, 5'h0, 1)); // pending error
    err_req <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    go(8'h62, 8'h00, 16'h0050, 16'h0010, 12'h080, nil); // inside limits
    go(8'h0F, 8'h18, 16'h0050, 16'h0010, 12'h100, nil); // legal limit
    chk(IDT_LIMIT, 16'h0050); // new limit
    go(8'hDD, 8'hC0, 16'h0, 16'h0008, 12'h200, nil); // last byte at FFFF
    chk({NPX_PTR_CS, NPX_PTR_IP}, {INSTR_CS, INSTR_IP}); // escape pointer
    repeat (2) @(posedge REF_CLK);
    chk(q.size(), 32'h0);
    final_report();
  end
endmodule // swap_lookup_exclusive_or_exec_test
`default_nettype wire
